// file: logic/lfs_pkg.sv
// package of constants for the led fault supervisor
// assumes a 25 MHz mclk; every other file but the interface imports this package
package lfs_pkg;

  // ----------------------------------------------------------------
  // register offsets on the two-wire bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STR_A   = 8'h05; // strings 1 and 2
  localparam logic [7:0] REG_STR_B   = 8'h06; // strings 3 and 4, masks
  localparam logic [7:0] REG_FAULT   = 8'h07; // converter faults
  localparam logic [7:0] REG_RST_VAL = 8'h00; // reset value of all three

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLT_TWARN  = 0; // temperature warning
  localparam int FLT_OTP    = 1; // over-temperature shutdown
  localparam int FLT_OC     = 2; // over-current
  localparam int FLT_OCSHDN = 3; // over-current hiccup shutdown
  localparam int STR_HI_OFS = 3; // upper string field starts here
  localparam int STR_OV     = 2; // high drain, within a string field
  localparam int STR_OPEN   = 1; // disconnect, within a string field
  localparam int STR_UNUSED = 0; // unused, within a string field
  localparam int MASK_S3    = 6; // mask bit of string 3 in REG_STR_B
  localparam int MASK_S4    = 7; // mask bit of string 4 in REG_STR_B

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int POR_TIME_US    = 100;
  localparam int POR_CYC        =
    (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_OFF_TICKS   = 4;   // gate off per over-current
  localparam int OC_WINDOW      = 128; // event counter clear period
  localparam int OC_EVENT_LIMIT = 4;   // events that trigger hiccup
  localparam int STRETCH_MS     = 8;   // fault output hold time
  localparam int FS_NOM_KOHM    = 100; // nominal frequency resistor
  localparam int STRETCH_CYC    =
    (STRETCH_MS * 1000000) / CLK_PERIOD_NS;

endpackage

// file: logic/lfs_core_if.sv
// signals shared between the supervisor top and its two helpers
// assumes every user sits on mclk
`timescale 1ns/1ps
interface lfs_core_if;
  logic ce;          // clock enable
  logic swTick;      // one switching clock period elapsed
  logic ocRt;        // real-time over-current comparator
  logic ssLow;       // soft-start cap below its restart level
  logic en;          // enable pin
  logic lowRailOk;   // low rail above its undervoltage limit
  logic upperRailOk; // upper rail ready
  logic gateOff;     // gate drive blanked after over-current
  logic hiccup;      // hiccup shutdown in progress
  logic ocEvent;     // pulse per over-current event
  logic shdnEvent;   // pulse when a hiccup starts
  logic lowRailEn;   // low rail regulator on
  logic upperRailEn; // upper rail regulator on
  logic porActive;   // power-on reset held
  logic coreRun;     // remaining circuitry released

  modport ocp (input ce, swTick, ocRt, ssLow, coreRun,
               output gateOff, hiccup, ocEvent, shdnEvent);
  modport seq (input ce, en, lowRailOk, upperRailOk,
               output lowRailEn, upperRailEn, porActive, coreRun);
endinterface

// file: logic/lfs_ocp.sv
// over-current blanking, event window and hiccup control
// assumes ocRt and swTick are synchronous to mclk
`timescale 1ns/1ps
module lfs_ocp
  import lfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  lfs_core_if.ocp  cif
);
  logic       ocRtQ;   // previous comparator level
  logic [2:0] offCntQ; // remaining blanking ticks
  logic [6:0] winCntQ; // window position
  logic [2:0] evCntQ;  // events in this window
  logic       hicQ;    // hiccup active

  wire winClr = cif.swTick && (winCntQ == 7'(OC_WINDOW - 1));
  wire lastEv = (evCntQ == 3'(OC_EVENT_LIMIT - 1));

  assign cif.ocEvent   = cif.ocRt && !ocRtQ;
  assign cif.shdnEvent = cif.ocEvent && lastEv && !hicQ;
  assign cif.gateOff   = (offCntQ != 3'h0);
  assign cif.hiccup    = hicQ;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ocRtQ   <= 1'b0;
      offCntQ <= 3'h0;
      winCntQ <= 7'h00;
      evCntQ  <= 3'h0;
      hicQ    <= 1'b0;
    end else if (cif.ce) begin
      ocRtQ <= cif.ocRt;
      // blank the gate for a fixed number of switching periods
      if (cif.ocEvent) begin
        offCntQ <= 3'(OC_OFF_TICKS); // RULE_11
      end else if (cif.swTick && offCntQ != 3'h0) begin
        offCntQ <= offCntQ - 3'h1; // RULE_11
      end
      if (cif.swTick) begin
        winCntQ <= winCntQ + 7'h01;
      end
      // window clear keeps a coincident event counted
      if (winClr) begin
        evCntQ <= cif.ocEvent ? 3'h1 : 3'h0; // RULE_12
      end else if (cif.shdnEvent) begin
        evCntQ <= 3'h0;
      end else if (cif.ocEvent && !hicQ) begin
        evCntQ <= evCntQ + 3'h1; // RULE_12
      end
      // hiccup holds until the cap is discharged, then restarts
      if (cif.shdnEvent) begin
        hicQ <= 1'b1; // RULE_13
      end else if (hicQ && cif.ssLow) begin
        hicQ <= 1'b0; // RULE_13
      end
      if (!cif.coreRun) begin
        evCntQ <= 3'h0;
        hicQ   <= 1'b0;
      end
    end
  end
endmodule

// file: logic/lfs_seq.sv
// start-up sequencer: low rail, upper rail, power-on reset, release
// assumes rail-ready inputs are synchronous comparator levels
`timescale 1ns/1ps
module lfs_seq
  import lfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  lfs_core_if.seq  cif
);
  typedef enum logic [2:0] {
    SQ_SLEEP = 3'h0,
    SQ_LOW   = 3'h1,
    SQ_UPPER = 3'h2,
    SQ_POR   = 3'h3,
    SQ_RUN   = 3'h4
  } lfs_seq_t;

  lfs_seq_t    stQ;    // sequencer state
  logic [11:0] porCntQ; // power-on reset timer

  assign cif.lowRailEn   = (stQ != SQ_SLEEP); // RULE_10
  assign cif.upperRailEn = (stQ == SQ_UPPER) || (stQ == SQ_POR)
                           || (stQ == SQ_RUN);
  assign cif.porActive   = (stQ == SQ_POR);
  assign cif.coreRun     = (stQ == SQ_RUN);

  // ----------------------------------------------------------------
  // state register; enable low always returns to sleep
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stQ     <= SQ_SLEEP;
      porCntQ <= 12'h000;
    end else if (cif.ce) begin
      if (!cif.en) begin
        stQ <= SQ_SLEEP; // RULE_10
      end else begin
        unique case (stQ)
          SQ_SLEEP: stQ <= SQ_LOW; // RULE_09
          SQ_LOW: begin
            if (cif.lowRailOk) stQ <= SQ_UPPER; // RULE_09
          end
          SQ_UPPER: begin
            porCntQ <= 12'h000;
            if (cif.upperRailOk) stQ <= SQ_POR; // RULE_09
          end
          SQ_POR: begin
            porCntQ <= porCntQ + 12'h001;
            if (porCntQ == 12'(POR_CYC - 1)) stQ <= SQ_RUN; // RULE_09
          end
          SQ_RUN: stQ <= SQ_RUN;
          default: stQ <= SQ_SLEEP;
        endcase
      end
    end
  end
endmodule

// file: logic/lfs_top.sv
// led driver fault supervisor: status latches, fault output,
// converter gating and the two-wire register slave
// assumes all pin inputs are synchronous to mclk; the bus data pin is
// open-drain and resolved outside from sdaOe
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) over-current events pull fault output low, stretched
// (RULE_02) read clears over-current and fault indication
// (RULE_03) temperature warning pulls fault output low
// (RULE_04) warning bit clears on read with warning low
// (RULE_05) warning set and clear within one microsecond
// (RULE_06) string over-voltage or open pulls fault low
// (RULE_07) string bits latch; only enable cycling clears
// (RULE_08) converter runs while any active string dims high
// (RULE_09) low rail, upper rail, reset, release after 100us
// (RULE_10) enable low means sleep, low rail off
// (RULE_11) over-current blanks gate four switching cycles
// (RULE_12) four-event counter cleared every 128 cycles
// (RULE_13) fourth event: stop, discharge soft-start, restart
// (RULE_14) over-current sets bit 2, read clears
// (RULE_15) over-temperature shuts down, sets bit 1
// (RULE_16) temperature warning always sets bit 0
// (RULE_17) fault output held about 8 ms, resistor scaled
// (RULE_18) hiccup sets bit 3; read or enable clears
// (RULE_19) bit 1 latches on over-temperature rising edge
// (RULE_20) fault output is OR of all indications
module lfs_top
  import lfs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = 7'h2A,       // arbitrary address
  parameter int         STRETCH_BASE = STRETCH_CYC, // 8 ms at nominal
  parameter int         FS_KOHM     = FS_NOM_KOHM, // resistor fitted
  parameter int         NUM_STR     = 4            // string count
)(
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  input  wire logic               en,
  input  wire logic               sclIn,
  input  wire logic               sdaIn,
  output wire logic               sdaOut,
  output wire logic               sdaOe,
  input  wire logic               swTick,
  input  wire logic               ocRt,
  input  wire logic               otpRt,
  input  wire logic               twarnRt,
  input  wire logic               ssLow,
  input  wire logic               lowRailOk,
  input  wire logic               upperRailOk,
  input  wire logic [NUM_STR-1:0] stringHighDrainRt,
  input  wire logic [NUM_STR-1:0] stringDisconnectRt,
  input  wire logic [NUM_STR-1:0] stringUnusedRt,
  input  wire logic [NUM_STR-1:0] pwmIn,
  output logic                    fault_out_n,
  output logic                    switch_gate_drive,
  output wire logic               softstart_cap_discharge,
  output wire logic               low_rail_en,
  output wire logic               upper_rail_en,
  output wire logic               porActive,
  output wire logic               coreRun
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_STR != 4) begin : g_badStr
    $error("lfs_top: register layout serves exactly four strings");
  end
  if (FS_KOHM < 1 || STRETCH_BASE < 1) begin : g_badStretch
    $error("lfs_top: stretch timer needs positive settings");
  end

  // stretch length scales linearly with the frequency resistor
  localparam longint STR_LEN = longint'(STRETCH_BASE) * FS_KOHM
                               / FS_NOM_KOHM;
  localparam int SW = $clog2(STR_LEN + 1);

  // ----------------------------------------------------------------
  // helper blocks
  // ----------------------------------------------------------------
  lfs_core_if cif ();

  assign cif.ce          = ce;
  assign cif.swTick      = swTick;
  assign cif.ocRt        = ocRt;
  assign cif.ssLow       = ssLow;
  assign cif.en          = en;
  assign cif.lowRailOk   = lowRailOk;
  assign cif.upperRailOk = upperRailOk;

  lfs_ocp u_ocp (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cif   (cif.ocp)
  );

  lfs_seq u_seq (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cif   (cif.seq)
  );

  assign low_rail_en             = cif.lowRailEn;
  assign upper_rail_en           = cif.upperRailEn;
  assign porActive               = cif.porActive;
  assign coreRun                 = cif.coreRun;
  assign softstart_cap_discharge = cif.hiccup; // RULE_13

  // ----------------------------------------------------------------
  // two-wire slave state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BS_IDLE  = 3'h0,
    BS_ADDR  = 3'h1,
    BS_ACKA  = 3'h2,
    BS_PTR   = 3'h3,
    BS_ACKW  = 3'h4,
    BS_WDATA = 3'h5,
    BS_SEND  = 3'h6,
    BS_MACK  = 3'h7
  } lfs_bus_t;

  lfs_bus_t   bsQ;      // bus state
  logic       sclQ;     // previous clock pin
  logic       sdaQ;     // previous data pin
  logic [7:0] shQ;      // receive shifter
  logic [7:0] txQ;      // transmit shifter
  logic [3:0] cntQ;     // bits in this byte
  logic       rwQ;      // read request
  logic       nackQ;    // master refused further bytes
  logic       oeQ;      // pulling data low
  logic [7:0] ptrQ;     // register pointer
  logic       rdDoneQ;  // one-cycle strobe at end of a read byte
  logic       wrMaskQ;  // write to the mask bits pending
  logic [1:0] maskQ;    // string 3/4 masks written by software

  wire sclRise  = sclIn && !sclQ;
  wire sclFall  = !sclIn && sclQ;
  wire busStart = sclIn && sclQ && sdaQ && !sdaIn;
  wire busStop  = sclIn && sclQ && !sdaQ && sdaIn;
  wire byteFull = (cntQ == 4'h8);
  wire addrHit  = (shQ[7:1] == DEV_ADDR);

  assign sdaOut = 1'b0;
  assign sdaOe  = oeQ;

  // ----------------------------------------------------------------
  // status latches
  // ----------------------------------------------------------------
  logic [NUM_STR-1:0] strOvQ;    // latched high drain per string
  logic [NUM_STR-1:0] strOpenQ;  // latched disconnect per string
  logic [NUM_STR-1:0] strUnusQ;  // latched unused per string
  logic               twarnQ;    // bit 0
  logic               otpQ;      // bit 1
  logic               ocQ;       // bit 2
  logic               ocShdnQ;   // bit 3
  logic               fltIndQ;   // fault output register indication
  logic               otpRtQ;    // previous over-temperature level
  logic [SW-1:0]      stretchQ;  // fault output hold counter

  // reads of the fault register clear on the byte end
  wire rdFault = rdDoneQ && (ptrQ == REG_FAULT);
  wire [NUM_STR-1:0] strMask = {maskQ[1], maskQ[0], 2'b00};

  // per-string latches; only enable low or reset clears them
  for (genvar i = 0; i < NUM_STR; i++) begin : g_str
    wire live = !strMask[i] && !strUnusQ[i] && cif.lowRailEn;
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        strOvQ[i]   <= 1'b0;
        strOpenQ[i] <= 1'b0;
        strUnusQ[i] <= 1'b0;
      end else if (ce) begin
        if (!en) begin
          strOvQ[i]   <= 1'b0; // RULE_07
          strOpenQ[i] <= 1'b0; // RULE_07
          strUnusQ[i] <= 1'b0; // RULE_07
        end else begin
          strUnusQ[i] <= strUnusQ[i] | stringUnusedRt[i]; // RULE_07
          strOvQ[i]   <= strOvQ[i] | (live & stringHighDrainRt[i]);
          strOpenQ[i] <= strOpenQ[i] | (live & stringDisconnectRt[i]);
        end
      end
    end
  end

  wire strFault = |(strOvQ | strOpenQ); // RULE_06

  // converter fault bits; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      twarnQ  <= 1'b0;
      otpQ    <= 1'b0;
      ocQ     <= 1'b0;
      ocShdnQ <= 1'b0;
      otpRtQ  <= 1'b0;
    end else if (ce) begin
      otpRtQ <= otpRt;
      // warning: set while high, clear on read only when low
      if (twarnRt) begin
        twarnQ <= 1'b1; // RULE_16
      end else if (rdFault) begin
        twarnQ <= 1'b0; // RULE_04
      end
      // shutdown bit latches on the rising edge only
      if (otpRt && !otpRtQ) begin
        otpQ <= 1'b1; // RULE_19
      end else if (rdFault && !otpRt) begin
        otpQ <= 1'b0; // RULE_15
      end
      // over-current: re-set while the condition stands
      if (cif.ocEvent || ocRt) begin
        ocQ <= 1'b1; // RULE_14
      end else if (rdFault || !en) begin
        ocQ <= 1'b0; // RULE_02
      end
      if (cif.shdnEvent) begin
        ocShdnQ <= 1'b1; // RULE_18
      end else if (rdFault || !en) begin
        ocShdnQ <= 1'b0; // RULE_18
      end
    end
  end

  // ----------------------------------------------------------------
  // fault output and stretch timer
  // ----------------------------------------------------------------
  wire anySet = cif.ocEvent || cif.shdnEvent || twarnRt || strFault; // RULE_03
  wire latched = twarnQ || otpQ || ocQ || ocShdnQ || strFault;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fltIndQ  <= 1'b0;
      stretchQ <= '0;
    end else if (ce) begin
      // indication re-arms by itself while a warning, over-current or string fault persists
      if (anySet || ocRt) begin
        fltIndQ <= 1'b1; // RULE_01
      end else if (rdFault) begin
        fltIndQ <= 1'b0; // RULE_02
      end
      // hold reloads while anything is active, runs down after
      if (latched || fltIndQ) begin
        stretchQ <= SW'(STR_LEN); // RULE_17
      end else if (stretchQ != '0) begin
        stretchQ <= stretchQ - SW'(1);
      end
    end
  end

  // registered output, one or two cycles from cause: well inside 1 us
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_out_n <= 1'b1;
    end else if (ce) begin
      fault_out_n <= !(anySet || latched || fltIndQ // RULE_20
                       || stretchQ != '0); // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // converter gating
  // ----------------------------------------------------------------
  wire [NUM_STR-1:0] activeStr = ~(strUnusQ | strMask);
  wire convOn = cif.coreRun && !otpRt && !cif.hiccup
                && |(pwmIn & activeStr); // RULE_08

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      switch_gate_drive <= 1'b0;
    end else if (ce) begin
      // over-temperature and hiccup both stop switching
      switch_gate_drive <= convOn && !cif.gateOff; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  wire [7:0] regA = {2'b00, strOvQ[0], strOpenQ[0], strUnusQ[0],
                     strOvQ[1], strOpenQ[1], strUnusQ[1]};
  wire [7:0] regB = {maskQ[1], maskQ[0],
                     strOvQ[2], strOpenQ[2], strUnusQ[2],
                     strOvQ[3], strOpenQ[3], strUnusQ[3]};
  wire [7:0] regF = {4'h0, ocShdnQ, ocQ, otpQ, twarnQ};
  wire [7:0] rdData = (ptrQ == REG_STR_A) ? regA :
                      (ptrQ == REG_STR_B) ? regB :
                      (ptrQ == REG_FAULT) ? regF : REG_RST_VAL;

  // ----------------------------------------------------------------
  // two-wire slave sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bsQ     <= BS_IDLE;
      sclQ    <= 1'b1;
      sdaQ    <= 1'b1;
      shQ     <= 8'h00;
      txQ     <= 8'h00;
      cntQ    <= 4'h0;
      rwQ     <= 1'b0;
      nackQ   <= 1'b0;
      oeQ     <= 1'b0;
      ptrQ    <= 8'h00;
      rdDoneQ <= 1'b0;
      wrMaskQ <= 1'b0;
      maskQ   <= 2'b00;
    end else if (ce) begin
      sclQ    <= sclIn;
      sdaQ    <= sdaIn;
      rdDoneQ <= 1'b0;
      wrMaskQ <= 1'b0;
      if (busStart) begin
        // start or repeated start resets the byte machine
        bsQ  <= BS_ADDR;
        cntQ <= 4'h0;
        oeQ  <= 1'b0;
      end else if (busStop) begin
        bsQ <= BS_IDLE;
        oeQ <= 1'b0;
      end else if (sclRise) begin
        // sample on the rising clock edge
        shQ  <= {shQ[6:0], sdaIn};
        cntQ <= cntQ + 4'h1;
        if (bsQ == BS_MACK) nackQ <= sdaIn;
      end else if (sclFall) begin
        // drive changes only while the clock is low
        unique case (bsQ)
          BS_IDLE: oeQ <= 1'b0;
          BS_ADDR: begin
            if (byteFull) begin
              bsQ <= addrHit ? BS_ACKA : BS_IDLE;
              oeQ <= addrHit;
              rwQ <= shQ[0];
            end
          end
          BS_ACKA: begin
            cntQ <= 4'h0;
            bsQ  <= rwQ ? BS_SEND : BS_PTR;
            oeQ  <= rwQ ? !rdData[7] : 1'b0;
            txQ  <= {rdData[6:0], 1'b0};
          end
          BS_PTR: begin
            if (byteFull) begin
              ptrQ <= shQ;
              bsQ  <= BS_ACKW;
              oeQ  <= 1'b1;
            end
          end
          BS_ACKW: begin
            cntQ <= 4'h0;
            bsQ  <= BS_WDATA;
            oeQ  <= 1'b0;
          end
          BS_WDATA: begin
            if (byteFull) begin
              // only the string masks accept writes
              wrMaskQ <= (ptrQ == REG_STR_B);
              bsQ     <= BS_ACKW;
              oeQ     <= 1'b1;
            end
          end
          BS_SEND: begin
            if (byteFull) begin
              oeQ     <= 1'b0;
              bsQ     <= BS_MACK;
              rdDoneQ <= 1'b1; // RULE_02
            end else begin
              oeQ <= !txQ[7];
              txQ <= {txQ[6:0], 1'b0};
            end
          end
          BS_MACK: begin
            cntQ <= 4'h0;
            bsQ  <= nackQ ? BS_IDLE : BS_SEND;
            oeQ  <= nackQ ? 1'b0 : !rdData[7];
            txQ  <= {rdData[6:0], 1'b0};
          end
        endcase
      end
      // mask bits take effect one cycle after the data byte
      if (wrMaskQ) begin
        maskQ <= {shQ[MASK_S4], shQ[MASK_S3]};
      end
    end
  end
endmodule

// file: dv/lfs_top_properties.sv
// pin-level assertions for the led fault supervisor
// assumes a bind onto lfs_top, all pins on mclk
`timescale 1ns/1ps
module lfs_top_properties
  import lfs_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       en,
  input wire logic       ocRt,
  input wire logic       otpRt,
  input wire logic       twarnRt,
  input wire logic [3:0] pwmIn,
  input wire logic       fault_out_n,
  input wire logic       switch_gate_drive,
  input wire logic       softstart_cap_discharge,
  input wire logic       low_rail_en,
  input wire logic       upper_rail_en,
  input wire logic       porActive,
  input wire logic       coreRun
);
  // ------------------------------------------------------------
  // sequencing, fault pin and gate relations
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_SLEEP: assert property (ce && !en |=> !low_rail_en)
    else $error("low rail on in sleep");
  AST_ORDER: assert property (upper_rail_en |-> low_rail_en)
    else $error("upper rail before low rail");
  AST_POR: assert property ($rose(coreRun) |-> $past(porActive))
    else $error("release without power-on reset");
  AST_WARN: assert property (
    ce && twarnRt |-> ##[1:24] !fault_out_n) else $error("warn not flagged");
  AST_OCFLT: assert property (
    ce && $rose(ocRt) |-> ##[1:2] !fault_out_n) else $error("oc not flagged");
  AST_BLANK: assert property (
    ce && $rose(ocRt) |-> ##[1:2] !switch_gate_drive)
    else $error("gate not blanked");
  AST_OTP: assert property (ce && otpRt |=> !switch_gate_drive)
    else $error("gate on while hot");
  AST_DIM: assert property (
    ce && pwmIn == 4'h0 |=> !switch_gate_drive) else $error("gate on dim low");
  // main scenarios seen
  cover property ($rose(coreRun));
  cover property ($rose(softstart_cap_discharge));
  cover property ($fell(fault_out_n));
endmodule

// file: dv/lfs_host_model.sv
// two-wire host reading one register per call via stored pointer
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module lfs_host_model
  import lfs_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2A // arbitrary address
)(
  input  wire logic mclk,
  input  wire logic sdaLine,
  output logic      scl = 1'h1,
  output logic      sda = 1'h1,
  output logic [7:0] rdData = 8'h00,
  output logic      rdDone = 1'h0
);
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves only while the clock is low, 4 mclk per phase
  task automatic bitx(input logic b, output logic r);
    sda <= b;
    wt(4);
    scl <= 1'h1;
    wt(4);
    r = sdaLine;
    scl <= 1'h0;
    wt(4);
  endtask
  task automatic startc();
    sda <= 1'h1;
    wt(2);
    scl <= 1'h1;
    wt(4);
    sda <= 1'h0;
    wt(4);
    scl <= 1'h0;
    wt(4);
  endtask
  task automatic stopc();
    sda <= 1'h0;
    wt(4);
    scl <= 1'h1;
    wt(4);
    sda <= 1'h1;
    wt(4);
  endtask
  // eight bits then the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) bitx(v[i], r[i]);
  endtask
  task automatic rd(input logic [7:0] ptr);
    logic [8:0] r;
    startc();
    xfer({ADDR, 2'h1}, r);
    xfer({ptr, 1'h1}, r);
    stopc();
    startc();
    xfer({ADDR, 2'h3}, r);
    xfer(9'h1FF, r);
    stopc();
    rdData <= r[8:1];
    rdDone <= 1'h1;
    wt(1);
    rdDone <= 1'h0;
  endtask
endmodule

// file: dv/lfs_top_tb.sv
// self-checking bench for the led fault supervisor
// assumes the host model as bus partner and rails that follow enables
`timescale 1ns/1ps
module lfs_top_tb;
  import lfs_pkg::*;
  logic mclk = 1'h0, rst_b = 1'h0, ce = 1'h1, en = 1'h0, sclIn, sdaH;
  logic swTick = 1'h0, ocRt = 1'h0, otpRt = 1'h0, twarnRt = 1'h0;
  logic ssLow = 1'h0, lowRailOk = 1'h0, upperRailOk = 1'h0, rdDone;
  logic [3:0] stringHighDrainRt = 4'h0, stringDisconnectRt = 4'h0;
  logic [3:0] stringUnusedRt = 4'h0, pwmIn = 4'h1;
  logic [7:0] rdData, expQ[$];
  wire logic sdaIn, sdaOut, sdaOe, fault_out_n, switch_gate_drive;
  wire logic softstart_cap_discharge, low_rail_en, upper_rail_en;
  wire logic porActive, coreRun;
  int n_fail = 0, total_checks = 0;
  assign sdaIn = sdaH & !sdaOe; // pull-up on the data line
  lfs_top #(.STRETCH_BASE(50)) dut_u (.mclk, .rst_b, .ce, .en, .sclIn,
    .sdaIn, .sdaOut, .sdaOe, .swTick, .ocRt, .otpRt, .twarnRt, .ssLow,
    .lowRailOk, .upperRailOk, .stringHighDrainRt, .stringDisconnectRt,
    .stringUnusedRt, .pwmIn, .fault_out_n, .switch_gate_drive,
    .softstart_cap_discharge, .low_rail_en, .upper_rail_en, .porActive,
    .coreRun);
  lfs_host_model host_u (.mclk, .sdaLine(sdaIn), .scl(sclIn), .sda(sdaH),
    .rdData, .rdDone);
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  // far-side analog: rails ready a cycle after enabled, cap follows
  always @(posedge mclk) begin
    swTick <= ~swTick;
    lowRailOk <= low_rail_en;
    upperRailOk <= upper_rail_en;
    ssLow <= softstart_cap_discharge;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] ptr, e);
    expQ.push_back(e);
    host_u.rd(ptr);
  endtask
  // oldest note against each finished read
  always @(posedge mclk) if (rdDone) chk("rdData", expQ.pop_front(), rdData);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    wt(20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hA65AB6EC));
    wt(2);
    rst_b <= 1'h1;
    wt(2);
    en <= 1'h1;
    for (int i = 0; i < 3000 && coreRun !== 1'h1; i++) wt(1);
    chk("coreRun", 8'h01, {7'h00, coreRun});
    for (int a = 5; a < 8; a++) rd(8'(a), REG_RST_VAL);
    pwmIn <= 4'h0;
    wt(3);
    chk("gate", 8'h00, {7'h00, switch_gate_drive});
    pwmIn <= 4'h1 | 4'($urandom);
    wt(3);
    chk("gate", 8'h01, {7'h00, switch_gate_drive});
    $display("test start-up done");
    twarnRt <= 1'h1;
    wt(5);
    twarnRt <= 1'h0;
    rd(REG_FAULT, 8'h01);
    rd(REG_FAULT, 8'h00);
    ocRt <= 1'h1;
    wt(1 + $urandom % 8);
    ocRt <= 1'h0;
    rd(REG_FAULT, 8'h04);
    rd(REG_FAULT, 8'h00);
    // seven events so one window always holds four
    repeat (7) begin
      ocRt <= 1'h1;
      wt(2);
      ocRt <= 1'h0;
      wt(10);
    end
    rd(REG_FAULT, 8'h0C);
    rd(REG_FAULT, 8'h00);
    otpRt <= 1'h1;
    wt(5);
    chk("gate", 8'h00, {7'h00, switch_gate_drive});
    otpRt <= 1'h0;
    rd(REG_FAULT, 8'h02);
    rd(REG_FAULT, 8'h00);
    $display("test converter faults done");
    stringDisconnectRt <= 4'h1;
    wt(5);
    stringDisconnectRt <= 4'h0;
    rd(REG_STR_A, 8'h10);
    chk("fault", 8'h00, {7'h00, fault_out_n});
    rd(REG_STR_A, 8'h10);
    en <= 1'h0;
    wt(5);
    en <= 1'h1;
    rd(REG_STR_A, 8'h00);
    rd(REG_FAULT, 8'h00);
    wt(100);
    chk("fault", 8'h01, {7'h00, fault_out_n});
    $display("test string faults done");
    end_of_test();
  end
endmodule
bind lfs_top lfs_top_properties chk_u (.mclk, .rst_b, .ce, .en, .ocRt,
  .otpRt, .twarnRt, .pwmIn, .fault_out_n, .switch_gate_drive,
  .softstart_cap_discharge, .low_rail_en, .upper_rail_en, .porActive,
  .coreRun);
